// File: src/motor_readout.sv
// Motor current and speed readout: converter sequencing, scaling, quadrature counting.
// Assumes converters with a control word port and a result queue, encoder pins from outside.
module motor_readout (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Sampling tick from the PWM unit
   input  wire logic        pwm_tick,
   // Converter control word and result queue
   output logic      [15:0] converter_control_word,
   output logic             ctrl_wr,
   input  wire logic [15:0] ctrl_status,
   output logic             conversion_result_queue_rd,
   input  wire logic [15:0] conversion_result_queue,
   // Encoder pins
   input  wire logic        enc_a,
   input  wire logic        enc_b,
   // Result stream to the control loops
   output logic             out_valid,
   input  wire logic        out_ready,
   output logic      [15:0] out_current_a,
   output logic      [15:0] out_current_b,
   output logic      [15:0] out_speed,
   output logic             out_speed_new
);

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [15:0] kcurrent_q;
   logic [15:0] kspeed_q;
   logic [15:0] period_q;
   logic        enable_q;
   logic [15:0] encoder_count_value_q;
   logic [15:0] pulses_q;
   logic [15:0] speed_acc_q;
   logic [15:0] speedstep_q;
   logic [15:0] speed_q;
   logic        speed_new_q;
   logic [15:0] ia_q;
   logic [15:0] ib_q;
   logic [9:0]  raw_a_q;
   logic [9:0]  raw_b_q;
   logic [9:0]  wait_q;
   logic        overrun_q;
   logic        sample_done_q;
   readout_pkg::conv_state_e conv_q;

   // ------------------------------------------------------------
   // Conversion time diagnostic
   // ------------------------------------------------------------
   // Shown in STATUS only; the busy flag alone ends the wait
   logic        slow_conv;
   assign slow_conv = wait_q == 10'(readout_pkg::CONV_CYCLES);

   // ------------------------------------------------------------
   // APB slave, zero wait states
   // ------------------------------------------------------------
   logic apb_wr;
   logic apb_rd;
   assign apb_wr = psel && penable && pwrite;
   assign apb_rd = psel && !penable && !pwrite;

   // Writes land at the access edge, the one at which pready stands
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         kcurrent_q <= readout_pkg::KCURRENT_RST;
         kspeed_q   <= readout_pkg::KSPEED_RST;
         period_q   <= readout_pkg::PERIOD_RST;
         enable_q   <= 1'b0;
      end else if (apb_wr) begin
         case (paddr)
            readout_pkg::ADDR_CTRL:     enable_q   <= pwdata[0];
            readout_pkg::ADDR_KCURRENT: kcurrent_q <= pwdata[15:0];
            readout_pkg::ADDR_KSPEED:   kspeed_q   <= pwdata[15:0];
            readout_pkg::ADDR_PERIOD:   period_q   <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // Read data is loaded in setup so it stands during the access phase
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         prdata  <= readout_pkg::ZERO_WORD;
         pslverr <= 1'b0;
         pready  <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         if (apb_rd) begin
            case (paddr)
               readout_pkg::ADDR_CTRL:      prdata <= {31'h0, enable_q};
               readout_pkg::ADDR_KCURRENT:  prdata <= {16'h0, kcurrent_q};
               readout_pkg::ADDR_KSPEED:    prdata <= {16'h0, kspeed_q};
               readout_pkg::ADDR_PERIOD:    prdata <= {16'h0, period_q};
               readout_pkg::ADDR_CURRENT_A: prdata <= {16'h0, ia_q};
               readout_pkg::ADDR_CURRENT_B: prdata <= {16'h0, ib_q};
               readout_pkg::ADDR_SPEED:     prdata <= {16'h0, speed_q};
               readout_pkg::ADDR_PULSES:    prdata <= {16'h0, pulses_q};
               readout_pkg::ADDR_STATUS:    prdata <= {29'h0, slow_conv, overrun_q, conv_q != readout_pkg::CONV_IDLE};
               default: begin
                  prdata  <= readout_pkg::ZERO_WORD;
                  pslverr <= 1'b1;
               end
            endcase
         end else if (psel && !penable) begin
            // Write setup: flag a bad address; the write itself is then dropped
            prdata  <= readout_pkg::ZERO_WORD;
            pslverr <= !(paddr <= readout_pkg::ADDR_STATUS && paddr[1:0] == 2'b00);
         end
      end
   end

   // ------------------------------------------------------------
   // Encoder pin synchronisers and quadrature decoder
   // ------------------------------------------------------------
   logic [2:0] sa_q;
   logic [2:0] sb_q;
   logic       a_q;
   logic       b_q;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sa_q <= 3'h0;
         sb_q <= 3'h0;
         a_q  <= 1'b0;
         b_q  <= 1'b0;
      end else begin
         sa_q <= {sa_q[1:0], enc_a};
         sb_q <= {sb_q[1:0], enc_b};
         // First stage may be metastable; only agreeing later stages are used
         if (sa_q[1] == sa_q[2]) a_q <= sa_q[2];
         if (sb_q[1] == sb_q[2]) b_q <= sb_q[2];
      end
   end

   // Every edge on either channel counts, direction from the phase order
   logic a_new;
   logic b_new;
   logic step;
   logic up;
   assign a_new = (sa_q[1] == sa_q[2]) ? sa_q[2] : a_q;
   assign b_new = (sb_q[1] == sb_q[2]) ? sb_q[2] : b_q;
   assign step  = (a_new != a_q) || (b_new != b_q);
   assign up    = (a_new != a_q) ? (a_new != b_q) : (b_new == a_q);

   // ------------------------------------------------------------
   // Per-sample capture and speed loop counter
   // ------------------------------------------------------------
   logic [15:0] count_step;
   logic [15:0] speed_sum;
   logic [31:0] speed_prod;
   assign count_step = up ? 16'h0001 : 16'hFFFF;
   // Sum before scaling so the shift truncates only once
   assign speed_sum  = speed_acc_q + pulses_q;
   assign speed_prod = $signed(speed_sum) * $signed(kspeed_q);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         encoder_count_value_q <= 16'h0000;
         pulses_q              <= 16'h0000;
      end else if (pwm_tick) begin
         // A step on the tick edge still belongs to the closing sample
         pulses_q              <= encoder_count_value_q + (step ? count_step : 16'h0000);
         encoder_count_value_q <= 16'h0000;
      end else if (step) begin
         encoder_count_value_q <= encoder_count_value_q + count_step;
      end
   end

   // Speed loop runs a cycle after capture so it sees the fresh count
   logic tick_d1_q;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) tick_d1_q <= 1'b0;
      else     tick_d1_q <= pwm_tick;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         speedstep_q <= readout_pkg::PERIOD_RST;
         speed_acc_q <= 16'h0000;
         speed_q     <= 16'h0000;
         speed_new_q <= 1'b0;
      end else begin
         speed_new_q <= 1'b0;
         if (tick_d1_q) begin
            if (speedstep_q <= 16'h0001) begin
               // Period expired: result uses this sample's pulses too
               speed_q     <= speed_prod[readout_pkg::FRAC_SHIFT +: 16];
               speed_new_q <= 1'b1;
               speed_acc_q <= 16'h0000;
               speedstep_q <= period_q;
            end else begin
               speed_acc_q <= speed_acc_q + pulses_q;
               speedstep_q <= speedstep_q - 16'h0001;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Converter sequencer and current scaling
   // ------------------------------------------------------------
   logic [10:0] sa_signed;
   logic [10:0] sb_signed;
   logic [31:0] prod_a;
   logic [31:0] prod_b;
   assign sa_signed = {1'b0, raw_a_q} - readout_pkg::MID_SCALE;
   assign sb_signed = {1'b0, raw_b_q} - readout_pkg::MID_SCALE;
   assign prod_a = $signed(sa_signed) * $signed(kcurrent_q);
   assign prod_b = $signed(sb_signed) * $signed(kcurrent_q);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         conv_q                     <= readout_pkg::CONV_IDLE;
         converter_control_word     <= 16'h0000;
         ctrl_wr                    <= 1'b0;
         conversion_result_queue_rd <= 1'b0;
         raw_a_q                    <= 10'h000;
         raw_b_q                    <= 10'h000;
         wait_q                     <= 10'h000;
         ia_q                       <= 16'h0000;
         ib_q                       <= 16'h0000;
         overrun_q                  <= 1'b0;
         sample_done_q              <= 1'b0;
      end else begin
         ctrl_wr                    <= 1'b0;
         conversion_result_queue_rd <= 1'b0;
         sample_done_q              <= 1'b0;
         // A tick during a sequence is dropped; overrun stays until reset
         if (pwm_tick && conv_q != readout_pkg::CONV_IDLE) overrun_q <= 1'b1;
         case (conv_q)
            readout_pkg::CONV_IDLE: begin
               if (pwm_tick && enable_q) begin
                  converter_control_word <= readout_pkg::CONV_START;
                  ctrl_wr                <= 1'b1;
                  wait_q                 <= 10'h000;
                  conv_q                 <= readout_pkg::CONV_START_WR;
               end
            end
            readout_pkg::CONV_START_WR: conv_q <= readout_pkg::CONV_WAIT;
            readout_pkg::CONV_WAIT: begin
               // Busy is polled; no read is issued while it is set
               if (!ctrl_status[readout_pkg::BUSY_BIT]) begin
                  conversion_result_queue_rd <= 1'b1;
                  conv_q                     <= readout_pkg::CONV_READ_A;
               end else if (wait_q != 10'(readout_pkg::CONV_CYCLES)) begin
                  wait_q <= wait_q + 10'h001;
               end
            end
            readout_pkg::CONV_READ_A: begin
               // Queue shows its head while the read strobe stands
               raw_a_q <= conversion_result_queue[readout_pkg::SAMPLE_MSB:readout_pkg::SAMPLE_LSB];
               conversion_result_queue_rd <= 1'b1;
               conv_q  <= readout_pkg::CONV_READ_B;
            end
            readout_pkg::CONV_READ_B: begin
               raw_b_q <= conversion_result_queue[readout_pkg::SAMPLE_MSB:readout_pkg::SAMPLE_LSB];
               conv_q  <= readout_pkg::CONV_SCALE;
            end
            readout_pkg::CONV_SCALE: begin
               ia_q          <= prod_a[readout_pkg::FRAC_SHIFT +: 16] - readout_pkg::RESID_OFFSET;
               ib_q          <= prod_b[readout_pkg::FRAC_SHIFT +: 16] - readout_pkg::RESID_OFFSET;
               sample_done_q <= 1'b1;
               conv_q        <= readout_pkg::CONV_IDLE;
            end
            default: conv_q <= readout_pkg::CONV_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Two-entry output buffer; a stalled receiver loses new samples once both entries are full
   // ------------------------------------------------------------
   logic [48:0] buf_q [2];
   logic [1:0]  cnt_q;
   logic        rd_ptr_q;
   logic        wr_ptr_q;
   logic        push;
   logic        pop;
   logic        spd_pend_q;
   logic        nxt_ptr;
   logic [1:0]  nxt_cnt;
   // A full buffer drops the new sample rather than a held one
   assign pop     = out_valid && out_ready;
   assign push    = sample_done_q && (cnt_q != 2'd2 || pop);
   assign nxt_ptr = pop ? !rd_ptr_q : rd_ptr_q;
   assign nxt_cnt = cnt_q + 2'(push) - 2'(pop);

   // Speed result marks the next current sample that enters the buffer
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)                spd_pend_q <= 1'b0;
      else if (speed_new_q)   spd_pend_q <= 1'b1;
      else if (push)          spd_pend_q <= 1'b0;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         buf_q[0] <= 49'h0;
         buf_q[1] <= 49'h0;
         cnt_q    <= 2'd0;
         rd_ptr_q <= 1'b0;
         wr_ptr_q <= 1'b0;
      end else begin
         if (push) begin
            buf_q[wr_ptr_q] <= {spd_pend_q || speed_new_q, speed_q, ib_q, ia_q};
            wr_ptr_q        <= !wr_ptr_q;
         end
         if (pop) rd_ptr_q <= !rd_ptr_q;
         cnt_q <= nxt_cnt;
      end
   end

   // ------------------------------------------------------------
   // Output stage, registered from the buffer head
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         out_valid     <= 1'b0;
         out_current_a <= 16'h0000;
         out_current_b <= 16'h0000;
         out_speed     <= 16'h0000;
         out_speed_new <= 1'b0;
      end else begin
         out_valid     <= nxt_cnt != 2'd0;
         out_current_a <= (push && nxt_cnt == 2'd1) ? ia_q : buf_q[nxt_ptr][15:0];
         out_current_b <= (push && nxt_cnt == 2'd1) ? ib_q : buf_q[nxt_ptr][31:16];
         out_speed     <= (push && nxt_cnt == 2'd1) ? speed_q : buf_q[nxt_ptr][47:32];
         out_speed_new <= (push && nxt_cnt == 2'd1) ? (spd_pend_q || speed_new_q) : buf_q[nxt_ptr][48];
      end
   end

endmodule

// File: src/readout_pkg.sv
// Constants, register map and encodings for the motor current and speed readout.
// Assumes a 100 MHz controller clock and an APB master with 32-bit data.
//
// Notes on behaviour
// - Use top ten bits of left-justified result
// - Subtract mid-scale 512 from each sample
// - Multiply by 8.8 scale, shift right eight
// - One control write starts both converters together
// - Poll busy flag, read after it clears
// - Subtract residual offset 112 after scaling
// - Count both edges of both encoder channels
// - Capture encoder count each sample, then clear
// - Speed counter decrements per tick, reloads period
// - Speed is pulses times 8.8 constant, shifted
// - Clear accumulated pulses after each speed result
// - Outputs are signed 16-bit 4.12 values
package readout_pkg;

   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [11:0] ADDR_CTRL      = 12'h000;
   localparam logic [11:0] ADDR_KCURRENT  = 12'h004;
   localparam logic [11:0] ADDR_KSPEED    = 12'h008;
   localparam logic [11:0] ADDR_PERIOD    = 12'h00C;
   localparam logic [11:0] ADDR_CURRENT_A = 12'h010;
   localparam logic [11:0] ADDR_CURRENT_B = 12'h014;
   localparam logic [11:0] ADDR_SPEED     = 12'h018;
   localparam logic [11:0] ADDR_PULSES    = 12'h01C;
   localparam logic [11:0] ADDR_STATUS    = 12'h020;

   // ------------------------------------------------------------
   // Reset values and fixed arithmetic
   // ------------------------------------------------------------
   localparam logic [15:0] KCURRENT_RST   = 16'h1383;
   localparam logic [15:0] KSPEED_RST     = 16'h0DA7;
   localparam logic [15:0] PERIOD_RST     = 16'h001E;
   localparam logic [15:0] CONV_START     = 16'h1801;
   localparam int          BUSY_BIT       = 8;
   localparam int          SAMPLE_MSB     = 15;
   localparam int          SAMPLE_LSB     = 6;
   localparam logic [10:0] MID_SCALE      = 11'h200;
   localparam logic [15:0] RESID_OFFSET   = 16'h0070;
   localparam int          FRAC_SHIFT     = 8;

   // Conversion time, the wait beyond which STATUS flags a slow conversion; busy alone ends the wait
   localparam int          CONV_TIME_NS   = 6000;
   localparam int          CLK_PERIOD_NS  = 10;
   localparam int          CONV_CYCLES    = CONV_TIME_NS / CLK_PERIOD_NS;

   localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;

   typedef enum {
      CONV_IDLE,
      CONV_START_WR,
      CONV_WAIT,
      CONV_READ_A,
      CONV_READ_B,
      CONV_SCALE
   } conv_state_e;

endpackage

// File: tb/motor_readout_sva.sv
// Port checker for motor_readout: APB answer, converter pacing, result stream.
// Assumes it is bound into motor_readout; one clock, rst async active high.
module motor_readout_sva (
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        rst,
   // APB answer
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Converter
   input wire logic [15:0] converter_control_word,
   input wire logic        ctrl_wr,
   input wire logic [15:0] ctrl_status,
   input wire logic        conversion_result_queue_rd,
   // Result stream
   input wire logic        out_valid,
   input wire logic        out_ready,
   input wire logic [15:0] out_current_a,
   input wire logic [15:0] out_current_b,
   input wire logic [15:0] out_speed
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_word; ctrl_wr |-> converter_control_word == readout_pkg::CONV_START; endproperty
   a_word: assert property (p_word) else $error("start word wrong");
   property p_wr_pulse; ctrl_wr |=> !ctrl_wr; endproperty
   a_wr_pulse: assert property (p_wr_pulse) else $error("start strobe too long");
   property p_rd_idle; conversion_result_queue_rd |-> !ctrl_status[readout_pkg::BUSY_BIT]; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("result read while busy");
   property p_no_early; ctrl_wr |=> !conversion_result_queue_rd [*2]; endproperty
   a_no_early: assert property (p_no_early) else $error("result read before poll");
   // Phase A then phase B: exactly two reads back to back
   property p_pair; $rose(conversion_result_queue_rd) |=> conversion_result_queue_rd ##1 !conversion_result_queue_rd;
   endproperty
   a_pair: assert property (p_pair) else $error("result reads not paired");
   property p_access; psel && penable |-> pready; endproperty
   a_access: assert property (p_access) else $error("access not answered");
   property p_err; pslverr |-> pready && prdata == readout_pkg::ZERO_WORD; endproperty
   a_err: assert property (p_err) else $error("error answer malformed");
   // A stalled word must not change, or the control loops see a torn sample
   property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_current_a) && $stable(out_current_b)
      && $stable(out_speed); endproperty
   a_hold: assert property (p_hold) else $error("stalled word changed");
endmodule

bind motor_readout motor_readout_sva motor_readout_sva_i (
   .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .converter_control_word(converter_control_word), .ctrl_wr(ctrl_wr),
   .ctrl_status(ctrl_status), .conversion_result_queue_rd(conversion_result_queue_rd),
   .out_valid(out_valid), .out_ready(out_ready), .out_current_a(out_current_a),
   .out_current_b(out_current_b), .out_speed(out_speed)
);

// File: tb/motor_readout_tb.sv
// Self-checking bench for motor_readout against the converter and encoder model.
// Assumes the package and design compiled first; ref_clk at 100 MHz.
module motor_readout_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic        pready, pslverr, rerr, pwm_tick = 1'b0, out_ready = 1'b0, ctrl_wr, q_rd;
   logic [15:0] ctrl_word, ctrl_status, q_word, word_a = 16'h0, word_b = 16'h0;
   logic        enc_a, enc_b, out_valid, out_speed_new, gn;
   logic [15:0] out_current_a, out_current_b, out_speed, ga, gb, gs;
   int          n_mismatch = 0, samples_checked = 0;
   motor_readout motor_readout_i (
      .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_tick(pwm_tick),
      .converter_control_word(ctrl_word), .ctrl_wr(ctrl_wr), .ctrl_status(ctrl_status),
      .conversion_result_queue_rd(q_rd), .conversion_result_queue(q_word), .enc_a(enc_a), .enc_b(enc_b),
      .out_valid(out_valid), .out_ready(out_ready), .out_current_a(out_current_a),
      .out_current_b(out_current_b), .out_speed(out_speed), .out_speed_new(out_speed_new));
   readout_partner readout_partner_i (
      .ref_clk(ref_clk), .rst(rst), .converter_control_word(ctrl_word), .ctrl_wr(ctrl_wr),
      .ctrl_status(ctrl_status), .conversion_result_queue_rd(q_rd), .conversion_result_queue(q_word),
      .word_a(word_a), .word_b(word_b), .enc_a(enc_a), .enc_b(enc_b));
   always #5 ref_clk = ~ref_clk;
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [15:0] bw(input logic [15:0] w);
      return {~w[15:6], 6'h15};
   endfunction
   // Offset 512, 8.8 scale with product bits 23:8, then trim of 112
   function automatic logic [15:0] expc(input logic [15:0] w, input logic [15:0] k);
      logic signed [31:0] p;
      p = ($signed({22'h0, w[15:6]}) - 32'sh200) * $signed({16'h0, k});
      return p[23:8] - 16'h0070;
   endfunction
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Tick, then the read pair, both samples, scaling and the push
   task automatic tick(input logic [15:0] wa);
      word_a <= wa;
      word_b <= bw(wa);
      @(posedge ref_clk);
      pwm_tick <= 1'b1;
      @(posedge ref_clk);
      pwm_tick <= 1'b0;
      while (q_rd !== 1'b1) begin
         @(posedge ref_clk);
      end
      repeat (5) @(posedge ref_clk);
   endtask
   task automatic pop();
      int n;
      n = 0;
      @(posedge ref_clk);
      out_ready <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (out_valid !== 1'b1 && n < 64);
      chk16({15'h0, out_valid}, 16'h0001);
      ga = out_current_a;
      gb = out_current_b;
      gs = out_speed;
      gn = out_speed_new;
      out_ready <= 1'b0;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs();
      apb(1'b0, readout_pkg::ADDR_KCURRENT, 32'h0);
      chk16(rdat[15:0], readout_pkg::KCURRENT_RST);
      apb(1'b0, readout_pkg::ADDR_KSPEED, 32'h0);
      chk16(rdat[15:0], readout_pkg::KSPEED_RST);
      apb(1'b0, readout_pkg::ADDR_PERIOD, 32'h0);
      chk16(rdat[15:0], readout_pkg::PERIOD_RST);
      apb(1'b0, 12'h024, 32'h0);
      chk16({15'h0, rerr}, 16'h0001);
   endtask
   // Two samples wait in the buffer while the receiver stalls
   task automatic t_currents();
      logic [15:0] w [4];
      logic [15:0] k;
      w = '{16'h0000, 16'h803F, 16'hA000, 16'h8040};
      k = readout_pkg::KCURRENT_RST;
      apb(1'b1, readout_pkg::ADDR_CTRL, 32'h1);
      for (int j = 0; j < 2; j++) begin
         if (j == 1) begin
            k = 16'h0100;
            apb(1'b1, readout_pkg::ADDR_KCURRENT, 32'h100);
         end
         tick(w[2*j]);
         tick(w[2*j+1]);
         for (int i = 0; i < 2; i++) begin
            pop();
            chk16(ga, expc(w[2*j+i], k));
            chk16(gb, expc(bw(w[2*j+i]), k));
         end
      end
   endtask
   // Three edges per tick, scale 2.0: counter left at 26 gives 156, then period 2 gives 12
   task automatic t_speed();
      int nres;
      nres = 0;
      apb(1'b1, readout_pkg::ADDR_KSPEED, 32'h200);
      apb(1'b1, readout_pkg::ADDR_PERIOD, 32'h2);
      for (int i = 0; i < 40; i++) begin
         readout_partner_i.step(3);
         repeat (6) @(posedge ref_clk);
         tick(16'h8000);
         pop();
         chk16({15'h0, gn}, {15'h0, i >= 25 && i % 2 == 1});
         if (gn === 1'b1) begin
            nres++;
            chk16(gs, (nres == 1) ? 16'h009C : 16'h000C);
         end
         apb(1'b0, readout_pkg::ADDR_PULSES, 32'h0);
         chk16(rdat[15:0], 16'h0003);
      end
      chk16({15'h0, nres >= 5}, 16'h0001);
   endtask
   task automatic results();
      $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      t_regs();
      t_currents();
      t_speed();
      results();
   end
   // Whole run needs about 2200 cycles
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_mismatch++;
      results();
   end
endmodule

// File: tb/readout_partner.sv
// Model of the two converters and the quadrature encoder.
// Assumes the readout's converter ports on the same clock; encoder moved by task step.
module readout_partner #(
   parameter int BUSY_CYC = 20
) (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // Converter side
   input  wire logic [15:0] converter_control_word,
   input  wire logic        ctrl_wr,
   output logic      [15:0] ctrl_status,
   input  wire logic        conversion_result_queue_rd,
   output logic      [15:0] conversion_result_queue,
   input  wire logic [15:0] word_a,
   input  wire logic [15:0] word_b,
   // Encoder pins
   output logic             enc_a,
   output logic             enc_b
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] busy_q;
   logic       second_q;
   // ----------------------------------------
   // Converters
   // ----------------------------------------
   // Only the word selecting both channels starts a conversion
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         busy_q <= 8'h00;
      end else if (ctrl_wr && converter_control_word == 16'h1801) begin
         busy_q <= BUSY_CYC[7:0];
      end else if (busy_q != 8'h00) begin
         busy_q <= busy_q - 8'h01;
      end
   end
   assign ctrl_status = {7'h00, busy_q != 8'h00, 8'h00};
   // Head word shows only while the read strobe stands, junk otherwise
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         second_q <= 1'b0;
      end else if (ctrl_wr) begin
         second_q <= 1'b0;
      end else if (conversion_result_queue_rd) begin
         second_q <= ~second_q;
      end
   end
   assign conversion_result_queue = conversion_result_queue_rd ? (second_q ? word_b : word_a)
                                                               : ~(second_q ? word_b : word_a);
   // ----------------------------------------
   // Encoder, A leading B
   // ----------------------------------------
   initial begin
      enc_a = 1'b0;
      enc_b = 1'b0;
   end
   task automatic step(input int n);
      repeat (n) begin
         @(posedge ref_clk);
         if (enc_a == enc_b)
            enc_a <= ~enc_a;
         else
            enc_b <= ~enc_b;
         repeat (3) @(posedge ref_clk);
      end
   endtask
endmodule
